/* File: core/sadc_core.sv */
/*
 * Frame control and serial result readout of a 12-bit successive
 * approximation converter. The host drives an active-low frame select
 * and a serial clock; both are sampled by the core clock. Sampled input
 * words arrive through a FIFO; the result leaves MSB first after four
 * zeros. Assumes the core clock is well above the serial clock rate.
 */
// What this block does
// - Frame select falling starts conversion and frame.
// - New bit presented after serial clock falling.
// - Sixteen bits: four zeros, result MSB first.
// - Conversion steps advance only on serial clock.
// - Hold begins at third serial clock falling.
// - Power down after conversion, up at frame.
// - Output starts driving after frame select falls.
// - Output releases after final falling edge.
`timescale 1ns/1ps
module sadc_core
    import sadc_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_srst,
    input  wire logic                   i_frame_sel_n,
    input  wire logic                   i_serial_clk,
    input  wire logic [RESULT_BITS-1:0] i_sample,
    input  wire logic                   i_sample_valid,
    output logic                        o_sample_ready,
    output logic                        o_serial_result_out,
    output logic                        o_serial_result_oe,
    output logic                        o_holding,
    output logic                        o_powered_down,
    output logic                        o_frame_done
);
    // The counter must reach one past a full frame; refuse this at
    // elaboration rather than let the count wrap in silence.
    if (FRAME_BITS >= (1 << CNT_W) || HOLD_EDGE >= FRAME_BITS) begin
        $error("sadc_core: frame does not fit the edge counter");
    end

    // Every register of the block outside the FIFO lives in this struct.
    typedef struct packed {
        logic                   cs_m;       // Select, first stage.
        logic                   cs_s;       // Select, second stage.
        logic                   cs_d;       // Select, previous sample.
        logic                   ck_m;       // Clock, first stage.
        logic                   ck_s;       // Clock, second stage.
        logic                   ck_d;       // Clock, previous sample.
        sadc_state_e            state;      // Frame sequencer.
        logic [CNT_W-1:0]       edges;      // Falling edges this frame.
        logic [RESULT_BITS-1:0] held;       // Held input word.
        logic [RESULT_BITS-1:0] trial;      // Approximation register.
        logic                   sdo;        // Serial output bit.
        logic                   oe;         // Serial output enable.
        logic                   pdown;      // Power-down flag.
        logic                   done;       // Frame complete pulse.
    } sadc_core_s;

    sadc_core_s             st;         // Registered state.
    sadc_core_s             next_st;    // Next state.
    logic [RESULT_BITS-1:0] fifo_data;  // Oldest sampled input word.
    logic                   fifo_valid; // FIFO holds a word.
    logic                   fifo_pop;   // Take the word at hold time.
    logic                   cs_fall;    // Frame select fell.
    logic                   cs_rise;    // Frame select rose.
    logic                   ck_fall;    // Serial clock fell.
    logic [RESULT_BITS-1:0] bit_mask;   // Trial bit of this step.

    // The analog front end is modelled as a stream of input words; the
    // FIFO lets the source run ahead while the host is between frames.
    sadc_fifo #(
        .WIDTH (RESULT_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_data     (i_sample),
        .i_valid    (i_sample_valid),
        .o_ready    (o_sample_ready),
        .o_data     (fifo_data),
        .o_valid    (fifo_valid),
        .i_ready    (fifo_pop)
    );

    // Cast helper so counter compares stay at counter width.
    function automatic logic [CNT_W-1:0] CNT_CAST(input int v);
        CNT_CAST = v[CNT_W-1:0];
    endfunction

    // Edge detection reads only second-stage and later samples.
    assign cs_fall = st.cs_d && !st.cs_s;
    assign cs_rise = !st.cs_d && st.cs_s;
    assign ck_fall = st.ck_d && !st.ck_s;

    // The word is taken from the FIFO at the instant of hold.
    assign fifo_pop = (st.state == SADC_TRACK) && ck_fall && !st.cs_s &&
                      (st.edges == CNT_CAST(HOLD_EDGE - 1));

    // Step k of the conversion tries bit (11 - k); the step index is
    // the edge count past the hold edge.
    assign bit_mask = (st.state == SADC_CONVERT &&
                       st.edges >= CNT_CAST(HOLD_EDGE) &&
                       st.edges < CNT_CAST(HOLD_EDGE + RESULT_BITS)) ?
        (RESULT_BITS'(1) << (RESULT_BITS - 1 -
            (int'(st.edges) - HOLD_EDGE))) : '0;

    // Sequencer, approximation and shifter.
    always_comb begin
        next_st      = st;
        next_st.cs_m = i_frame_sel_n;
        next_st.cs_s = st.cs_m;
        next_st.cs_d = st.cs_s;
        next_st.ck_m = i_serial_clk;
        next_st.ck_s = st.ck_m;
        next_st.ck_d = st.ck_s;
        next_st.done = 1'b0;

        case (st.state)
            SADC_IDLE: begin
                // A new frame powers up and starts driving zeros.
                if (cs_fall) begin
                    next_st.state = SADC_TRACK;
                    next_st.edges = CNT_ZERO;
                    next_st.pdown = 1'b0;
                    next_st.oe    = 1'b1;
                    next_st.sdo   = 1'b0;
                    next_st.trial = '0;
                end
            end
            SADC_TRACK: begin
                if (st.cs_s) begin
                    // Select rose early: abandon and release.
                    next_st.state = SADC_IDLE;
                    next_st.oe    = 1'b0;
                    next_st.pdown = 1'b1;
                end else if (ck_fall) begin
                    next_st.edges = st.edges + 1'b1;
                    next_st.sdo   = 1'b0;
                    if (st.edges == CNT_CAST(HOLD_EDGE - 1)) begin
                        // Hold on the third falling edge.
                        next_st.held  = fifo_valid ? fifo_data : '0;
                        next_st.state = SADC_CONVERT;
                    end
                end
            end
            SADC_CONVERT: begin
                if (st.cs_s) begin
                    next_st.state = SADC_IDLE;
                    next_st.oe    = 1'b0;
                    next_st.pdown = 1'b1;
                end else if (ck_fall) begin
                    next_st.edges = st.edges + 1'b1;
                    if (bit_mask != '0) begin
                        // Trial compare decides one bit per edge.
                        if ((st.trial | bit_mask) <= st.held) begin
                            next_st.trial = st.trial | bit_mask;
                        end
                    end
                    // Edges 1..3 send zeros; edge 4 on sends result.
                    if (st.edges < CNT_CAST(LEAD_ZEROS - 1)) begin
                        next_st.sdo = 1'b0;
                    end else if (st.edges == CNT_CAST(LEAD_ZEROS - 1))
                    begin
                        // MSB decided at this same step goes out first.
                        next_st.sdo   = ((st.trial | bit_mask) <=
                                         st.held) ? 1'b1 : 1'b0;
                    end else if (st.edges <
                                 CNT_CAST(FRAME_BITS - 1)) begin
                        // Later bits are read from the trial register
                        // once that step has resolved them.
                        next_st.sdo = next_st.trial[RESULT_BITS - 1 -
                            (int'(st.edges) - (LEAD_ZEROS - 1))];
                    end else begin
                        // Final falling edge: release and sleep.
                        next_st.oe    = 1'b0;
                        next_st.state = SADC_DONE;
                        next_st.pdown = 1'b1;
                        next_st.done  = 1'b1;
                    end
                end
            end
            SADC_DONE: begin
                // Wait for select to return high before rearming;
                // the host keeps the quiet interval itself.
                if (st.cs_s) begin
                    next_st.state = SADC_IDLE;
                end
            end
            default: begin
                next_st.state = SADC_IDLE;
            end
        endcase
    end

    // Single state register with synchronous reset.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            st       <= '0;
            st.cs_m  <= 1'b1;
            st.cs_s  <= 1'b1;
            st.cs_d  <= 1'b1;
            // The serial clock idles high; starting the stages at that
            // level keeps a false edge out of the first cycles.
            st.ck_m  <= 1'b1;
            st.ck_s  <= 1'b1;
            st.ck_d  <= 1'b1;
            st.state <= SADC_IDLE;
            st.pdown <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_serial_result_out = st.sdo;
    assign o_serial_result_oe  = st.oe;
    assign o_holding           = (st.state == SADC_CONVERT);
    assign o_powered_down      = st.pdown;
    assign o_frame_done        = st.done;
endmodule

/* File: core/sadc_pkg.sv */
/*
 * Constants shared by the serial converter readout block: frame layout,
 * edge positions within a frame, and the interframe quiet figure.
 * Assumes nothing of its surroundings; holds definitions only.
 */
package sadc_pkg;
    // Result resolution in bits.
    localparam int RESULT_BITS      = 12;
    // Leading zero bits ahead of the result.
    localparam int LEAD_ZEROS       = 4;
    // Total bits shifted out per frame.
    localparam int FRAME_BITS       = LEAD_ZEROS + RESULT_BITS;
    // Falling edge of the serial clock at which the input is held.
    localparam int HOLD_EDGE        = 3;
    // Least quiet time between release and next frame, in ns.
    localparam int QUIET_NS         = 10;
    // Core clock period in ns.
    localparam int CORE_PERIOD_NS   = 10;
    // Quiet time in core cycles, rounded up, at least one.
    localparam int QUIET_CYCLES     =
        ((QUIET_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS) < 1 ? 1 :
        ((QUIET_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
    // Width of the edge counter within a frame.
    localparam int CNT_W            = 5;
    // Counter value that marks a fresh frame.
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

    // Frame sequencer states.
    typedef enum logic [1:0] {
        SADC_IDLE,
        SADC_TRACK,
        SADC_CONVERT,
        SADC_DONE
    } sadc_state_e;
endpackage

/* File: core/sadc_fifo.sv */
/*
 * Synchronous FIFO carrying sampled input words to the converter.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module sadc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_srst,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic      [WIDTH-1:0] o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);

    // The pointer arithmetic wraps naturally only on powers of two,
    // so other depths are refused at elaboration.
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
        $error("sadc_fifo: DEPTH must be a power of two >= 2");
    end

    // All state in one struct; storage array kept apart for inference.
    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } sadc_fifo_s;

    sadc_fifo_s       st;       // Registered state.
    sadc_fifo_s       next_st;  // Next state.
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;     // Write accepted this cycle.
    logic             pop;      // Read accepted this cycle.

    assign o_ready = (st.count != (AW+1)'(DEPTH));
    assign o_valid = (st.count != '0);
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_data  = mem[st.rd_ptr];

    // Pointer and occupancy update.
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr_ptr = st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register and storage write.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
        if (push) begin
            mem[st.wr_ptr] <= i_data;
        end
    end
endmodule

/* File: dv/sadc_core_props.sv */
/* Checker for the converter readout core, bound to its ports.
   Assumes one core clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module sadc_core_props (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_frame_sel_n,
    input wire logic i_serial_clk,
    input wire logic o_serial_result_out,
    input wire logic o_serial_result_oe,
    input wire logic o_holding,
    input wire logic o_powered_down,
    input wire logic o_frame_done
);
    logic       sclk_q; // Last sample of the serial clock pin.
    logic [4:0] falls;  // Serial clock falls seen in this frame.

    // Count pin falls per frame; a high select clears the count.
    always_ff @(posedge i_core_clk) begin
        sclk_q <= i_serial_clk;
        if (i_srst || i_frame_sel_n) falls <= 5'h00;
        else if (sclk_q && !i_serial_clk) falls <= falls + 5'h01;
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    // Opening of a frame, and a select that has settled high.
    sequence s_open; $fell(i_frame_sel_n); endsequence
    sequence s_idle; i_frame_sel_n [*6]; endsequence

    a_oe_after_open: assert property (
        s_open |-> ##[2:6] o_serial_result_oe)
        else $error("output not enabled after select fall");
    a_oe_rise_cause: assert property (
        $rose(o_serial_result_oe) |-> !i_frame_sel_n && falls == 5'h00)
        else $error("output enabled outside a frame start");
    a_idle_released: assert property (
        s_idle |-> !o_serial_result_oe && !o_holding)
        else $error("output or hold active while select idle");
    a_done_releases: assert property (
        o_frame_done |-> ##[0:1] (!o_serial_result_oe && o_powered_down))
        else $error("line not released at frame end");
    a_done_single: assert property (
        o_frame_done |=> !o_frame_done)
        else $error("frame done longer than one cycle");
    a_done_sixteenth: assert property (
        o_frame_done |-> falls == 5'h10)
        else $error("frame done not at sixteenth fall");
    a_hold_third_edge: assert property (
        $rose(o_holding) |-> falls == 5'h03)
        else $error("hold not at third fall");
    a_bit_after_fall: assert property (
        o_serial_result_oe && $past(o_serial_result_oe) &&
        $changed(o_serial_result_out) |-> !$past(i_serial_clk, 2))
        else $error("data changed without a clock fall");
    a_lead_zeros: assert property (
        !i_frame_sel_n && o_serial_result_oe && falls < 5'h04
        |-> !o_serial_result_out)
        else $error("leading bit not zero");
    a_power_up_open: assert property (
        s_open |-> ##[2:6] !o_powered_down)
        else $error("no power up at frame start");
endmodule

bind sadc_core sadc_core_props i_props (.i_core_clk, .i_srst,
    .i_frame_sel_n, .i_serial_clk, .o_serial_result_out,
    .o_serial_result_oe, .o_holding, .o_powered_down, .o_frame_done);

/* File: dv/sadc_host_model.sv */
/* Host model: drives frame select and serial clock, reads the word.
   Assumes a released data line reads as the inverse of its data. */
`timescale 1ns/1ps
module sadc_host_model (
    input  wire logic i_sdo,
    input  wire logic i_oe,
    output logic      o_frame_sel_n,
    output logic      o_serial_clk
);
    logic line; // Level the host sees on the shared data line.

    // A released line must never pass for valid data, so invert it.
    assign line = i_oe ? i_sdo : ~i_sdo;

    // Both lines idle high; the clock stands still between frames.
    initial begin
        o_frame_sel_n = 1'b1;
        o_serial_clk  = 1'b1;
    end

    // One frame of n falls; fewer than sixteen abandons it.
    task automatic frame(input int n, output logic [15:0] word);
        #3.1 o_frame_sel_n = 1'b0;
        #100 word[15] = line;
        for (int k = 1; k <= n; k++) begin
            #62.5 o_serial_clk = 1'b0;
            #62.5 o_serial_clk = 1'b1;
            if (k < 16) word[15-k] = line;
        end
        #100 o_frame_sel_n = 1'b1;
        #200;
    endtask
endmodule

/* File: dv/testbench.sv */
/* Self-checking bench for the readout core: fills and drains the
   sample FIFO and checks each full-frame word read by the host model.
   Assumes the checker is bound to the core. */
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    err_total++; $display("MISMATCH %0t got %h exp %h", $time, got, \
    exp); end end
module testbench
    import sadc_pkg::*;
;
    logic        clk    = 1'b0;    // Core clock.
    logic        srst   = 1'b1;    // Synchronous reset.
    logic [11:0] sample = 12'h000; // Word offered to the FIFO.
    logic        svalid = 1'b0;    // Offer strobe.
    logic [31:0] rnd;              // Latest random draw.
    logic [15:0] word;             // Word read by the host.
    logic [11:0] expq[$];          // Words the core must return.
    logic        sel_n, sclk, sready, sdo, oe, holding, pdown, done;
    integer      seed = 32'hC5A73065;
    int          err_total = 0;
    int          checked = 0;

    // Core clock at 100 MHz.
    always #5 clk = ~clk;

    sadc_core #(.FIFO_DEPTH(32)) i_dut (
        .i_core_clk          (clk),
        .i_srst              (srst),
        .i_frame_sel_n       (sel_n),
        .i_serial_clk        (sclk),
        .i_sample            (sample),
        .i_sample_valid      (svalid),
        .o_sample_ready      (sready),
        .o_serial_result_out (sdo),
        .o_serial_result_oe  (oe),
        .o_holding           (holding),
        .o_powered_down      (pdown),
        .o_frame_done        (done)
    );
    sadc_host_model i_host (.i_sdo(sdo), .i_oe(oe),
        .o_frame_sel_n(sel_n), .o_serial_clk(sclk));

    // Leading zeros, then the held word MSB first.
    function automatic logic [15:0] exp_word(input logic [11:0] r);
        return {{LEAD_ZEROS{1'b0}}, r};
    endfunction

    // Offer n words back to back; the first two are the extremes.
    task automatic push_n(input int n);
        for (int k = 0; k < n; k++) begin
            rnd = $random(seed);
            svalid <= 1'b1;
            sample <= (k < 2) ? {12{k == 1}} : rnd[11:0];
            @(posedge clk);
            if (sready === 1'b1) expq.push_back(sample);
        end
        svalid <= 1'b0;
    endtask

    // Run a frame of n falls; check the word on a full frame, the released line on a shorter one.
    task automatic frame_chk(input int n);
        logic [11:0] e;
        e = 12'h000;
        // Start off a core clock edge so pin changes never meet one.
        @(posedge clk);
        i_host.frame(n, word);
        if (n >= HOLD_EDGE && expq.size() > 0) e = expq.pop_front();
        if (n == FRAME_BITS) `CHK(word, exp_word(e))
        else `CHK(oe, 1'b0)
        `CHK(pdown, 1'b1)
    endtask

    // Print the counts and the verdict, then stop.
    task automatic tally_and_finish;
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Main sequence: full buffer, aborts at the hold boundary, drain.
    initial begin
        repeat (4) @(posedge clk);
        `CHK({oe, pdown, holding, done, sready}, 5'h09)
        srst <= 1'b0;
        @(posedge clk);
        push_n(34);
        `CHK(expq.size(), 32)
        `CHK(sready, 1'b0)
        frame_chk(2);
        frame_chk(3);
        for (int f = 0; f < 31; f++) frame_chk(FRAME_BITS);
        `CHK(sready, 1'b1)
        frame_chk(FRAME_BITS);
        for (int f = 1; f < 4; f++) begin
            @(posedge clk);
            push_n(f);
            repeat (f) frame_chk(FRAME_BITS);
        end
        tally_and_finish();
    end

    // A hang counts as a mismatch and ends the run.
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
endmodule
